// [rtl/dlf_pkg.sv]
package dlf_pkg;

	// register bus shape
	localparam int DLF_AW = 4;
	localparam int DLF_DW = 8;

	// register offsets
	localparam logic [3:0] DLF_OFS_TRIM_LO   = 4'h0;
	localparam logic [3:0] DLF_OFS_TRIM_HI   = 4'h1;
	localparam logic [3:0] DLF_OFS_DAMP      = 4'h2;
	localparam logic [3:0] DLF_OFS_ACQ_BW    = 4'h3;
	localparam logic [3:0] DLF_OFS_LOCK_BW   = 4'h4;
	localparam logic [3:0] DLF_OFS_AUTO_SEL  = 4'h5;
	localparam logic [3:0] DLF_OFS_STATUS    = 4'h6;

	// field positions
	localparam int DLF_STAT_BW_LSB   = 0;
	localparam int DLF_STAT_DAMP_LSB = 4;

	// reset values
	localparam logic [15:0] DLF_TRIM_RST    = 16'h9999;
	localparam logic [2:0]  DLF_DAMP_RST    = 3'h3;
	localparam logic [3:0]  DLF_ACQ_BW_RST  = 4'h8;
	localparam logic [3:0]  DLF_LOCK_BW_RST = 4'h3;
	localparam logic        DLF_AUTO_RST    = 1'b1;

	// bandwidth steps: 0.1,0.3,0.6,1.2,2.5,4,8,18,35,70 Hz
	localparam int         DLF_BW_STEPS = 10;
	localparam logic [3:0] DLF_BW_MAX   = 4'h9;
	localparam logic [3:0] DLF_BW_4HZ   = 4'h5;
	localparam logic [3:0] DLF_BW_8HZ   = 4'h6;
	localparam logic [3:0] DLF_BW_18HZ  = 4'h7;
	localparam logic [3:0] DLF_BW_35HZ  = 4'h8;
	localparam logic [3:0] DLF_BW_70HZ  = 4'h9;

	// filter scaling
	localparam logic [4:0] DLF_SHIFT_BASE = 5'h14;
	localparam int         DLF_TRIM_SHIFT = 4;

	// damping codes as written by software
	localparam logic [2:0] DLF_DCODE_1 = 3'h1;
	localparam logic [2:0] DLF_DCODE_2 = 3'h2;
	localparam logic [2:0] DLF_DCODE_3 = 3'h3;
	localparam logic [2:0] DLF_DCODE_4 = 3'h4;
	localparam logic [2:0] DLF_DCODE_5 = 3'h5;

	// damping factors selected
	typedef enum logic [2:0] {
		DLF_DAMP_1P2 = 3'b000,
		DLF_DAMP_2P5 = 3'b001,
		DLF_DAMP_5   = 3'b010,
		DLF_DAMP_10  = 3'b011,
		DLF_DAMP_20  = 3'b100
	} dlf_damp_type;

	// register bus request
	typedef struct packed {
		logic [DLF_AW-1:0] addr;
		logic [DLF_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} dlf_bus_req_type;

endpackage

// [rtl/dlf_damping_decode.sv]
`timescale 1ns/1ps

module dlf_damping_decode
	import dlf_pkg::*;
(
	// selection inputs
	input  wire logic [3:0]   bw_index,
	input  wire logic [2:0]   damp_code,
	// decoded factor
	output dlf_damp_type      damp_factor
);

	// table lookup of damping factor against bandwidth
	always_comb begin
		damp_factor = DLF_DAMP_5; // reserved codes act as factor 5
		if (bw_index <= DLF_BW_4HZ) begin
			damp_factor = DLF_DAMP_5;
		end else if (bw_index == DLF_BW_8HZ) begin
			case (damp_code)
				DLF_DCODE_1: damp_factor = DLF_DAMP_2P5;
				default:     damp_factor = DLF_DAMP_5;
			endcase
		end else if (bw_index == DLF_BW_18HZ) begin
			case (damp_code)
				DLF_DCODE_1: damp_factor = DLF_DAMP_1P2;
				DLF_DCODE_2: damp_factor = DLF_DAMP_2P5;
				default:     damp_factor = DLF_DAMP_5;
			endcase
		end else if (bw_index == DLF_BW_35HZ) begin
			case (damp_code)
				DLF_DCODE_1: damp_factor = DLF_DAMP_1P2;
				DLF_DCODE_2: damp_factor = DLF_DAMP_2P5;
				DLF_DCODE_4: damp_factor = DLF_DAMP_10;
				DLF_DCODE_5: damp_factor = DLF_DAMP_10;
				default:     damp_factor = DLF_DAMP_5;
			endcase
		end else begin
			case (damp_code)
				DLF_DCODE_1: damp_factor = DLF_DAMP_1P2;
				DLF_DCODE_2: damp_factor = DLF_DAMP_2P5;
				DLF_DCODE_4: damp_factor = DLF_DAMP_10;
				DLF_DCODE_5: damp_factor = DLF_DAMP_20;
				default:     damp_factor = DLF_DAMP_5;
			endcase
		end
	end

endmodule

// [rtl/dlf_phase_lowpass.sv]
`timescale 1ns/1ps

module dlf_phase_lowpass
	import dlf_pkg::*;
#(
	parameter int PW = 16,
	parameter int AW = 32
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// phase sample
	input  wire logic signed [PW-1:0] phase_in,
	input  wire logic                 phase_valid,
	// settings
	input  wire logic [3:0]           bw_index,
	input  dlf_damp_type              damp_factor,
	// filtered phase
	output logic signed [AW-1:0]      filt_out
);

	typedef struct packed {
		logic signed [AW-1:0] integ;
		logic signed [AW-1:0] out;
	} dlf_lp_state_type;

	dlf_lp_state_type state;
	dlf_lp_state_type next_state;

	// pole position from bandwidth, proportional path from damping
	always_comb begin
		logic signed [AW-1:0] err;
		logic [4:0]           pole_shift;
		logic [4:0]           prop_shift;
		err        = '0;
		pole_shift = DLF_SHIFT_BASE - 5'(bw_index);
		prop_shift = pole_shift - 5'(damp_factor);
		next_state = state;
		if (phase_valid) begin
			err = AW'(phase_in) - state.integ;
			next_state.integ = state.integ + (err >>> pole_shift);
			next_state.out   = next_state.integ + (err >>> prop_shift);
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign filt_out = state.out;

endmodule

// [rtl/dlf_loop_filter_config.sv]
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps


module dlf_loop_filter_config
	import dlf_pkg::*;
#(
	parameter int          PW           = 16,
	parameter int          FW           = 32,
	parameter logic [31:0] NOMINAL_WORD = 32'h4000_0000
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// register port
	input  wire logic [DLF_AW-1:0]    reg_addr,
	input  wire logic [DLF_DW-1:0]    reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [DLF_DW-1:0]         reg_rdata,
	// phase detector side
	input  wire logic signed [PW-1:0] phase_in,
	input  wire logic                 phase_valid,
	input  wire logic                 phase_locked,
	// loop outputs
	output logic [FW-1:0]             freq_word,
	output logic [3:0]                active_bandwidth,
	output dlf_damp_type              active_damping
);

	typedef struct packed {
		logic [15:0]       oscillator_trim_word;
		logic [2:0]        loop_damping_select;
		logic [3:0]        acquisition_bandwidth_setting;
		logic [3:0]        locked_bandwidth_setting;
		logic              automatic_bandwidth_select;
		logic [DLF_DW-1:0] rdata;
		logic [3:0]        bw;
		dlf_damp_type      damp;
		logic [FW-1:0]     freq;
	} dlf_cfg_state_type;

	dlf_cfg_state_type state;
	dlf_cfg_state_type next_state;
	dlf_bus_req_type   req;
	dlf_damp_type      decoded_damp;
	logic signed [FW-1:0] filt_out;
	logic [3:0]        bw_sel;

	// bundle the bus signals
	assign req.addr  = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr    = reg_wr;
	assign req.rd    = reg_rd;

	// bandwidth selection between acquisition and locked settings
	always_comb begin
		if (state.automatic_bandwidth_select && !phase_locked) begin
			bw_sel = state.acquisition_bandwidth_setting;
		end else begin
			bw_sel = state.locked_bandwidth_setting;
		end
		if (bw_sel > DLF_BW_MAX) begin
			bw_sel = DLF_BW_MAX; // only ten steps exist
		end
	end

	// damping factor from code and current bandwidth
	dlf_damping_decode u_damp (
		.bw_index    (bw_sel),
		.damp_code   (state.loop_damping_select),
		.damp_factor (decoded_damp)
	);

	// phase low-pass filter
	dlf_phase_lowpass #(
		.PW (PW),
		.AW (FW)
	) u_lowpass (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.phase_in    (phase_in),
		.phase_valid (phase_valid),
		.bw_index    (state.bw),
		.damp_factor (state.damp),
		.filt_out    (filt_out)
	);

	// register writes, reads and output word
	always_comb begin
		logic signed [FW-1:0] trim_delta;
		trim_delta = FW'(signed'({1'b0, state.oscillator_trim_word}))
			- FW'(signed'({1'b0, DLF_TRIM_RST})); // zero at reset
		next_state       = state;
		next_state.rdata = '0;
		if (req.wr) begin
			case (req.addr)
				DLF_OFS_TRIM_LO: begin
					next_state.oscillator_trim_word[7:0] = req.wdata;
				end
				DLF_OFS_TRIM_HI: begin
					next_state.oscillator_trim_word[15:8] = req.wdata;
				end
				DLF_OFS_DAMP: begin
					next_state.loop_damping_select = req.wdata[2:0];
				end
				DLF_OFS_ACQ_BW: begin
					next_state.acquisition_bandwidth_setting = req.wdata[3:0];
				end
				DLF_OFS_LOCK_BW: begin
					next_state.locked_bandwidth_setting = req.wdata[3:0];
				end
				DLF_OFS_AUTO_SEL: begin
					next_state.automatic_bandwidth_select = req.wdata[0];
				end
				default: begin
					next_state.rdata = '0;
				end
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				DLF_OFS_TRIM_LO: begin
					next_state.rdata = state.oscillator_trim_word[7:0];
				end
				DLF_OFS_TRIM_HI: begin
					next_state.rdata = state.oscillator_trim_word[15:8];
				end
				DLF_OFS_DAMP: begin
					next_state.rdata = {5'h00, state.loop_damping_select};
				end
				DLF_OFS_ACQ_BW: begin
					next_state.rdata = {4'h0, state.acquisition_bandwidth_setting};
				end
				DLF_OFS_LOCK_BW: begin
					next_state.rdata = {4'h0, state.locked_bandwidth_setting};
				end
				DLF_OFS_AUTO_SEL: begin
					next_state.rdata = {7'h00, state.automatic_bandwidth_select};
				end
				DLF_OFS_STATUS: begin
					next_state.rdata[DLF_STAT_BW_LSB +: 4]   = state.bw;
					next_state.rdata[DLF_STAT_DAMP_LSB +: 3] = state.damp;
				end
				default: begin
					next_state.rdata = '0;
				end
			endcase
		end
		next_state.bw   = bw_sel;
		next_state.damp = decoded_damp;
		// linear trim added to every output frequency
		next_state.freq = FW'(NOMINAL_WORD) + filt_out
			+ (trim_delta <<< DLF_TRIM_SHIFT);
	end

	// state register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state.oscillator_trim_word <= DLF_TRIM_RST;
			state.loop_damping_select  <= DLF_DAMP_RST;
			state.acquisition_bandwidth_setting <= DLF_ACQ_BW_RST;
			state.locked_bandwidth_setting      <= DLF_LOCK_BW_RST;
			state.automatic_bandwidth_select    <= DLF_AUTO_RST;
			state.rdata <= '0;
			state.bw    <= DLF_LOCK_BW_RST;
			state.damp  <= DLF_DAMP_5;
			state.freq  <= FW'(NOMINAL_WORD);
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flops
	assign reg_rdata        = state.rdata;
	assign freq_word        = state.freq;
	assign active_bandwidth = state.bw;
	assign active_damping   = state.damp;

endmodule

// [verification/dlf_loop_filter_config_props.sv]
`timescale 1ns/1ps

module dlf_loop_filter_config_props
	import dlf_pkg::*;
#(
	parameter int          FW           = 32,
	parameter logic [31:0] NOMINAL_WORD = 32'h4000_0000
) (
	// clock and reset
	input wire logic          core_clk,
	input wire logic          sys_rst,
	// register port
	input wire logic [3:0]    reg_addr,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [7:0]    reg_rdata,
	// loop side
	input wire logic          phase_valid,
	input wire logic [FW-1:0] freq_word,
	input wire logic [3:0]    active_bandwidth,
	input dlf_damp_type       active_damping
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// building blocks
	sequence s_held; $stable(active_bandwidth); endsequence
	sequence s_bad_rd; reg_rd && reg_addr > DLF_OFS_STATUS; endsequence
	sequence s_quiet; (!phase_valid && !reg_wr)[*3]; endsequence

	a_rdata_idle:
		assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata");
	a_bad_read:
		assert property (s_bad_rd |=> reg_rdata == 8'h00) else $error("map");
	a_bw_range:
		assert property (active_bandwidth <= DLF_BW_MAX) else $error("bw");
	a_low_damp:
		assert property (s_held ##0 active_bandwidth <= DLF_BW_4HZ
			|-> active_damping == DLF_DAMP_5) else $error("low bw damp");
	a_damp_2p5:
		assert property (s_held ##0 active_damping == DLF_DAMP_2P5
			|-> active_bandwidth >= DLF_BW_8HZ) else $error("2.5");
	a_damp_1p2:
		assert property (s_held ##0 active_damping == DLF_DAMP_1P2
			|-> active_bandwidth >= DLF_BW_18HZ) else $error("1.2");
	a_damp_10:
		assert property (s_held ##0 active_damping == DLF_DAMP_10
			|-> active_bandwidth >= DLF_BW_35HZ) else $error("10");
	a_damp_20:
		assert property (s_held ##0 active_damping == DLF_DAMP_20
			|-> active_bandwidth == DLF_BW_70HZ) else $error("20");
	a_reset_word:
		assert property ($fell(sys_rst) |-> freq_word == NOMINAL_WORD)
			else $error("reset word");
	a_freq_hold:
		assert property (s_quiet |=> $stable(freq_word)) else $error("drift");
endmodule

bind dlf_loop_filter_config dlf_loop_filter_config_props #(
	.FW(FW), .NOMINAL_WORD(NOMINAL_WORD)
) u_props (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
	.phase_valid, .freq_word, .active_bandwidth, .active_damping);

// [verification/dpll_loop_filter_config_tb.sv]
`timescale 1ns/1ps

module dpll_loop_filter_config_tb;
	import dlf_pkg::*;
	localparam logic [31:0] NOM = 32'h4000_0000;
	logic               core_clk, sys_rst, reg_wr, reg_rd, rd_seen;
	logic               phase_valid, phase_locked;
	logic [3:0]         reg_addr, active_bandwidth, bx;
	logic [7:0]         reg_wdata, reg_rdata, ev, st;
	logic signed [15:0] phase_in;
	logic [31:0]        freq_word;
	logic [15:0]        trim;
	dlf_damp_type       active_damping;
	logic [7:0]         exp_q[$];
	int                 error_cnt, cmp_count, seed;

	dlf_loop_filter_config #(.NOMINAL_WORD(NOM)) u_dut (.core_clk,
		.sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.phase_in, .phase_valid, .phase_locked, .freq_word,
		.active_bandwidth, .active_damping);

	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		cmp_word({24'h0, g}, {24'h0, e});
	endtask

	// strobes stay up between calls so no signal is set twice per step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		exp_q.push_back(e);
		@(posedge core_clk);
	endtask

	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask

	task automatic tally_and_finish;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// expected damping encoding for a bandwidth step and a code
	// code steps up from an offset set by bandwidth, capped per step
	function automatic logic [2:0] exp_damp(input logic [3:0] b, input int c);
		int lo, hi;
		lo = (b <= 5) ? 2 : (b == 6) ? 1 : 0;
		hi = (b <= 7) ? 2 : (b == 8) ? 3 : 4;
		if (c < 1 || c > 5) return 3'h2;
		return 3'((c - 1 + lo > hi) ? hi : c - 1 + lo);
	endfunction

	// read data checked in the cycle after each read strobe
	always @(posedge core_clk) begin
		if (rd_seen) begin
			ev = exp_q.pop_front();
			cmp_byte(reg_rdata, ev);
		end
		rd_seen <= reg_rd;
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		seed = 32;
		{error_cnt, cmp_count} = '0;
		{reg_wr, reg_rd, phase_valid, reg_addr} = '0;
		{reg_wdata, phase_in} = '0;
		phase_locked = 1'b1;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		idle(1);
		// reset values, then an unmapped place
		rd(DLF_OFS_TRIM_LO, 8'h99);
		rd(DLF_OFS_TRIM_HI, 8'h99);
		rd(DLF_OFS_DAMP, 8'h03);
		rd(DLF_OFS_ACQ_BW, 8'h08);
		rd(DLF_OFS_LOCK_BW, 8'h03);
		rd(DLF_OFS_AUTO_SEL, 8'h01);
		rd(DLF_OFS_STATUS, 8'h23);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		// manual mode: every code at every step, lock input random
		wr(DLF_OFS_AUTO_SEL, 8'h00);
		for (int b = 0; b <= 10; b++) begin
			for (int c = 0; c < 8; c++) begin
				bx = (b > 9) ? 4'h9 : 4'(b);
				phase_locked <= 1'($random(seed));
				wr(DLF_OFS_LOCK_BW, (b > 9) ? 8'h0C : 8'(b));
				wr(DLF_OFS_DAMP, 8'(c));
				st = {1'b0, exp_damp(bx, c), bx};
				idle(3);
				cmp_byte({1'b0, active_damping, active_bandwidth}, st);
				rd(DLF_OFS_STATUS, st);
			end
		end
		// automatic mode: acquisition step until lock
		wr(DLF_OFS_AUTO_SEL, 8'h01);
		wr(DLF_OFS_ACQ_BW, 8'h09);
		wr(DLF_OFS_LOCK_BW, 8'h02);
		wr(DLF_OFS_DAMP, 8'h05);
		for (int i = 0; i < 4; i++) begin
			phase_locked <= i[0];
			idle(3);
			rd(DLF_OFS_STATUS, i[0] ? 8'h22 : 8'h49);
		end
		// trim word: both ends, then random codes
		for (int i = 0; i < 6; i++) begin
			trim = (i == 0) ? 16'h0 : (i == 1) ? 16'hFFFF : 16'($random(seed));
			wr(DLF_OFS_TRIM_LO, trim[7:0]);
			wr(DLF_OFS_TRIM_HI, trim[15:8]);
			idle(3);
			cmp_word(freq_word, NOM + ((32'(trim) - 32'h9999) << 4));
			rd(DLF_OFS_TRIM_HI, trim[15:8]);
		end
		wr(DLF_OFS_TRIM_LO, 8'h99);
		wr(DLF_OFS_TRIM_HI, 8'h99);
		wr(DLF_OFS_LOCK_BW, 8'h09);
		idle(3);
		cmp_word(freq_word, NOM);
		// steady positive phase error must move the word
		phase_valid <= 1'b1;
		repeat (200) begin
			phase_in <= {2'b01, 14'($random(seed))};
			@(posedge core_clk);
		end
		phase_valid <= 1'b0;
		idle(4);
		cmp_word(32'(freq_word > NOM), 32'h1);
		// second reset in mid-run
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		idle(1);
		cmp_word(freq_word, NOM);
		rd(DLF_OFS_TRIM_LO, 8'h99);
		rd(DLF_OFS_DAMP, 8'h03);
		rd(DLF_OFS_STATUS, 8'h23);
		idle(2);
		tally_and_finish();
	end
endmodule
